// ==== core/bsi_pkg.sv ====
// Types shared by the serial interrupt/port block
`default_nettype none

package bsi_pkg;
  // Meaning of bit locations 1..15
  typedef enum logic {BSI_MODE_IRQ, BSI_MODE_TMR} bsi_mode_t;
  typedef logic [4:0] bsi_bit_t;
  typedef logic [13:0] bsi_tmr_t;
endpackage

`default_nettype wire

// ==== core/bsi_regs.svh ====
// Bit map locations, reset values and timing counts of the serial interrupt/port block
`ifndef BSI_REGS_SVH
`define BSI_REGS_SVH

// Bit locations on the bit-serial bus
`define BSI_BIT_MODE 5'h00
`define BSI_BIT_IRQ_LO 5'h01
`define BSI_BIT_TMR_HI 5'h0e
`define BSI_BIT_IRQ15 5'h0f
`define BSI_BIT_PORT_LO 5'h10
`define BSI_BIT_SEL_W 5

// Interrupt slot shared with the timer
`define BSI_TIMER_SLOT 4'h3

// Level codes
`define BSI_CODE_RESET 4'h0
`define BSI_CODE_IDLE 4'hf

// Reset values
`define BSI_MASK_RST 15'h0000
`define BSI_PORT_DIR_RST 16'h0000
`define BSI_PORT_OUT_RST 16'h0000
`define BSI_BUS_SYNC_RST 8'h80
`define BSI_PIN_SYNC_RST 22'h3fffff
`define BSI_TMR_RST 14'h0000

// Timer decrements once every 64 core clocks
`define BSI_TMR_PRESCALE_MAX 6'h3f

`endif

// ==== core/bsi_timer.sv ====
// Countdown timer that shares the slot-three interrupt
`include "bsi_regs.svh"
`default_nettype none

module bsi_timer (
  input wire logic i_core_clk, // Core clock
  input wire logic i_srst, // Synchronous reset, high
  input wire logic i_load, // Load new start value, pulse
  input wire logic [13:0] i_load_val, // New start value
  input wire logic i_capture, // Latch count for event read, pulse
  input wire logic i_irq_clear, // Clear timer interrupt, pulse
  output logic o_enabled, // Start value nonzero
  output logic o_irq, // Timer interrupt, sticky
  output logic [13:0] o_start, // Current start value
  output logic [13:0] o_capture_val // Latched count
);

  logic [5:0] pre_q;
  bsi_pkg::bsi_tmr_t start_q;
  bsi_pkg::bsi_tmr_t cnt_q;
  logic irq_q;
  bsi_pkg::bsi_tmr_t cap_q;
  logic tick;
  logic expire;

  // Zero start value means disabled
  assign o_enabled = (start_q != `BSI_TMR_RST);
  assign tick = o_enabled && (pre_q == `BSI_TMR_PRESCALE_MAX);
  assign expire = tick && (cnt_q == 14'h0001);

  // Prescaler restarts on every load so each write restarts the period
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst || i_load || !o_enabled)
      pre_q <= 6'h00;
    else
      pre_q <= 6'(pre_q + 6'h01);
  end

  // Start value register
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      start_q <= `BSI_TMR_RST;
    else if (i_load)
      start_q <= i_load_val; // R20
  end

  // Decrementer, reloads in place of stepping from 1 to 0
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      cnt_q <= `BSI_TMR_RST;
    else if (i_load)
      cnt_q <= i_load_val;
    else if (expire)
      cnt_q <= start_q;
    else if (tick)
      cnt_q <= 14'(cnt_q - 14'h0001);
  end

  // Set wins over a clear in the same cycle so no expiry is lost
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      irq_q <= 1'b0;
    else if (expire)
      irq_q <= 1'b1;
    else if (i_irq_clear)
      irq_q <= 1'b0;
  end

  // Event timer snapshot
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      cap_q <= `BSI_TMR_RST;
    else if (i_capture)
      cap_q <= cnt_q;
  end

  assign o_irq = irq_q;
  assign o_start = start_q;
  assign o_capture_val = cap_q;

  // A disabled timer never raises its interrupt
  a_tmr_off_quiet: assert property (@(posedge i_core_clk) disable iff (i_srst) // R20
    (!o_enabled && !o_irq && !i_load) |=> !o_irq)
    else $error("timer interrupt raised while disabled");

endmodule

`default_nettype wire

// ==== core/bsi_top.sv ====
// Bit-serial bus interrupt encoder and 16-bit port interface
//
// How it works
// [R1] Chip select low: five select lines, first most significant, address 32 bits.
// [R2] Write strobe edge stores the serial write line into the selected bit.
// [R3] The selected bit's value is driven onto the serial read line.
// [R4] Each synchronised interrupt input, low and masked on, reaches the encoder.
// [R5] Lowest-numbered enabled input wins; its number goes out with request low.
// [R6] No enabled input active: request high and code 1111.
// [R7] Code and request are registered, updated one clock after sampling.
// [R8] Outputs stay constant while the enabled active set is unchanged.
// [R9] When the winner goes away the next enabled input is shown.
// [R10] Reset forces code 0000, request high, and clears every mask.
// [R11] Bit 0 is the mode bit: 0 interrupt mode, 1 timer mode.
// [R12] Interrupt mode: writing bit n sets or clears mask n.
// [R13] Reads 1..15 give pin levels, or timer value and request in timer mode.
// [R14] Timer mode: writing zero to bit 15 soft-resets the ports.
// [R15] Reads 16..31 give port pin levels without disturbing outputs.
// [R16] Writing bits 16..31 makes that port an output driving the value.
// [R17] Six dedicated interrupt pins, nine shared pins, seven pure ports.
// [R18] Host clears the mask of a pin it uses as plain input.
// [R19] Timer enabled: slot three is the timer, pin three cannot interrupt.
// [R20] Timer mode writes 1..14 load the start value; nonzero enables.
// [R21] Power and soft reset return all ports to input.
// [R22] Host clears the timer interrupt by writing mask bit three.
// [R23] Chip select high: write strobes ignored, nothing changes.
`include "bsi_regs.svh"
`default_nettype none

module bsi_top (
  input wire logic i_core_clk, // Core clock, 25 MHz
  input wire logic i_srst, // Synchronous reset, high
  input wire logic i_chip_select_n, // Bus chip select, low
  input wire logic [4:0] i_bit_select, // Bit number, [4] first line
  input wire logic i_serial_write_line, // Write data bit
  input wire logic i_write_strobe, // Write strobe, rising edge
  output logic o_serial_read_line, // Read data bit
  output logic o_irq_request_n, // Interrupt request, low
  output logic [3:0] o_level_code, // Level code, [3] first line
  input wire logic [6:1] i_irq_inputs_n, // Dedicated interrupt pins
  input wire logic [15:0] i_port_pins, // Port pin levels
  output logic [15:0] o_port_pins, // Port output data
  output logic [15:0] o_port_pins_oe // Port output enables
);

  // Synchroniser stages for host and pin inputs
  logic [7:0] bus_s1_q;
  logic [7:0] bus_s2_q;
  logic [21:0] pin_s1_q;
  logic [21:0] pin_s2_q;
  logic strobe_q;

  // Decoded bus fields after the second stage
  logic cs_n_s;
  bsi_pkg::bsi_bit_t sel_s;
  logic wdata_s;
  logic strobe_s;
  logic wr_pulse;
  logic wr_irq_bits;
  logic wr_tmr_bits;

  // Block state
  bsi_pkg::bsi_mode_t mode_q;
  logic [15:1] mask_q;
  logic [15:0] port_out_q;
  logic [15:0] port_dir_q;
  logic [3:0] code_q;
  logic req_n_q;
  logic rd_q;
  logic rd_d;

  // Combinational helpers
  logic [15:1] lvl_n;
  logic [15:0] port_lvl;
  logic [15:1] act;
  logic tmr_mode;
  logic soft_rst;

  // Timer interface
  logic tmr_load;
  bsi_pkg::bsi_tmr_t tmr_load_val;
  logic tmr_capture;
  logic tmr_irq_clear;
  logic tmr_en;
  logic tmr_irq;
  bsi_pkg::bsi_tmr_t tmr_start;
  bsi_pkg::bsi_tmr_t tmr_cap;

  // Lowest-numbered active slot wins; empty set gives the idle code
  function automatic logic [3:0] bsi_prio(input logic [15:1] req);
    logic [3:0] code;
    code = `BSI_CODE_IDLE;
    for (int n = 15; n >= 1; n--)
    begin
      if (req[n])
        code = 4'(n);
    end
    return code;
  endfunction

  // Two flops on every pin; the first stage feeds only the second
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      bus_s1_q <= `BSI_BUS_SYNC_RST;
      bus_s2_q <= `BSI_BUS_SYNC_RST;
    end
    else
    begin
      bus_s1_q <= {i_chip_select_n, i_bit_select, i_serial_write_line, i_write_strobe};
      bus_s2_q <= bus_s1_q;
    end
  end

  // Interrupt and port pin synchronisers
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      pin_s1_q <= `BSI_PIN_SYNC_RST;
      pin_s2_q <= `BSI_PIN_SYNC_RST;
    end
    else
    begin
      pin_s1_q <= {i_irq_inputs_n, i_port_pins};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Strobe history for edge detection, taken after synchronising
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      strobe_q <= 1'b0;
    else
      strobe_q <= strobe_s;
  end

  assign cs_n_s = bus_s2_q[7];
  assign sel_s = bus_s2_q[6:2]; // R1
  assign wdata_s = bus_s2_q[1];
  assign strobe_s = bus_s2_q[0];
  assign port_lvl = pin_s2_q[15:0];

  // Write only on a strobe edge with the chip selected
  assign wr_pulse = strobe_s && !strobe_q && !cs_n_s; // R2 R23
  assign tmr_mode = (mode_q == bsi_pkg::BSI_MODE_TMR);
  assign wr_irq_bits = wr_pulse && !tmr_mode && (sel_s >= `BSI_BIT_IRQ_LO)
    && (sel_s <= `BSI_BIT_IRQ15);
  assign wr_tmr_bits = wr_pulse && tmr_mode && (sel_s >= `BSI_BIT_IRQ_LO)
    && (sel_s <= `BSI_BIT_TMR_HI);
  assign soft_rst = wr_pulse && tmr_mode && (sel_s == `BSI_BIT_IRQ15)
    && !wdata_s; // R14

  // Pin levels per slot: 1..6 dedicated, 7..15 shared with ports 15..7
  always_comb
  begin
    lvl_n[6:1] = pin_s2_q[21:16];
    for (int n = 7; n <= 15; n++)
    begin
      lvl_n[n] = port_lvl[22 - n]; // R17
    end
  end

  // Active low pin gated by its mask; timer takes slot three when running
  always_comb
  begin
    act = ~lvl_n & mask_q; // R4
    if (tmr_en)
      act[`BSI_TIMER_SLOT] = tmr_irq && mask_q[`BSI_TIMER_SLOT]; // R19
  end

  // Mode bit
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      mode_q <= bsi_pkg::BSI_MODE_IRQ;
    else if (wr_pulse && (sel_s == `BSI_BIT_MODE))
      mode_q <= wdata_s ? bsi_pkg::BSI_MODE_TMR : bsi_pkg::BSI_MODE_IRQ; // R11
  end

  // Mask bits, only changed in interrupt mode
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      mask_q <= `BSI_MASK_RST; // R10
    else if (wr_irq_bits)
      mask_q[sel_s[3:0]] <= wdata_s; // R12
  end

  // Port outputs; a write turns the pin around, resets turn it back
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      port_out_q <= `BSI_PORT_OUT_RST;
      port_dir_q <= `BSI_PORT_DIR_RST; // R21
    end
    else if (soft_rst)
      port_dir_q <= `BSI_PORT_DIR_RST; // R21
    else if (wr_pulse && sel_s[4])
    begin
      port_out_q[sel_s[3:0]] <= wdata_s; // R16
      port_dir_q[sel_s[3:0]] <= 1'b1; // R16
    end
  end

  assign o_port_pins = port_out_q;
  assign o_port_pins_oe = port_dir_q;

  // Timer hooks; one bit of the start value is replaced per write
  always_comb
  begin
    tmr_load_val = tmr_start;
    tmr_load_val[4'(sel_s[3:0] - 4'h1)] = wdata_s; // R20
  end

  assign tmr_load = wr_tmr_bits; // R20
  assign tmr_capture = wr_pulse && (sel_s == `BSI_BIT_MODE) && wdata_s;
  // Either written value clears the timer interrupt
  assign tmr_irq_clear = wr_irq_bits && (sel_s[3:0] == `BSI_TIMER_SLOT); // R22

  bsi_timer u_timer (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_load(tmr_load),
    .i_load_val(tmr_load_val),
    .i_capture(tmr_capture),
    .i_irq_clear(tmr_irq_clear),
    .o_enabled(tmr_en),
    .o_irq(tmr_irq),
    .o_start(tmr_start),
    .o_capture_val(tmr_cap)
  );

  // Read data mux; reads never touch state
  always_comb
  begin
    rd_d = 1'b0;
    if (sel_s == `BSI_BIT_MODE)
      rd_d = tmr_mode; // R11
    else if (sel_s[4])
      rd_d = port_lvl[sel_s[3:0]]; // R15
    else if (!tmr_mode)
      rd_d = lvl_n[sel_s[3:0]]; // R13
    else if (sel_s == `BSI_BIT_IRQ15)
      rd_d = req_n_q; // R13
    else
      rd_d = tmr_cap[4'(sel_s[3:0] - 4'h1)]; // R13
  end

  // Registered read line toward the host
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      rd_q <= 1'b0;
    else
      rd_q <= rd_d; // R3
  end

  assign o_serial_read_line = rd_q;

  // Code and request registered one clock after sampling, like the
  // inverted-phase update, so the host never sees a mid-change code
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      code_q <= `BSI_CODE_RESET; // R10
      req_n_q <= 1'b1; // R10
    end
    else
    begin
      code_q <= bsi_prio(act); // R5 R6 R7 R8 R9
      req_n_q <= ~|act; // R5 R6
    end
  end

  assign o_level_code = code_q;
  assign o_irq_request_n = req_n_q;

  // Released reset leaves code 0000, request high, masks clear
  a_reset_state: assert property (@(posedge i_core_clk) disable iff (i_srst) // R10
    $past(i_srst) |-> (o_level_code == 4'h0) && o_irq_request_n && (mask_q == 15'h0000)
      && (o_port_pins_oe == 16'h0000))
    else $error("reset did not set code, request, masks and ports");
  // Idle set shows code 1111 with request high next clock
  a_idle_code: assert property (@(posedge i_core_clk) disable iff (i_srst) // R6
    (act == 15'h0000) |=> (o_level_code == 4'hf) && o_irq_request_n)
    else $error("idle outputs not high");
  // Slot one always wins when active
  a_top_prio: assert property (@(posedge i_core_clk) disable iff (i_srst) // R5
    act[1] |=> (o_level_code == 4'h1) && !o_irq_request_n)
    else $error("slot one not encoded");
  // With every mask clear the request stays high next clock
  a_mask_gate: assert property (@(posedge i_core_clk) disable iff (i_srst) // R4
    (mask_q == 15'h0000) |=> o_irq_request_n)
    else $error("request with all masks clear");
  // Code holds while the active set holds
  a_code_hold: assert property (@(posedge i_core_clk) disable iff (i_srst) // R8
    (!$past(i_srst) && (act == $past(act))) |=> $stable(o_level_code)
      && $stable(o_irq_request_n))
    else $error("code changed with no cause");
  // A low pin three never shows as level three while the timer is enabled and quiet
  a_slot_three: assert property (@(posedge i_core_clk) disable iff (i_srst) // R19
    (tmr_en && !tmr_irq && !lvl_n[3]) |=> (o_level_code != 4'h3))
    else $error("pin three reached encoder while timer on");
  // Mask write lands next clock
  a_mask_write: assert property (@(posedge i_core_clk) disable iff (i_srst) // R12
    wr_irq_bits |=> (mask_q[$past(sel_s[3:0])] == $past(wdata_s)))
    else $error("mask write lost");
  // Port write turns pin to output with data
  a_port_write: assert property (@(posedge i_core_clk) disable iff (i_srst) // R16
    (wr_pulse && sel_s[4]) |=> o_port_pins_oe[$past(sel_s[3:0])]
      && (o_port_pins[$past(sel_s[3:0])] == $past(wdata_s)))
    else $error("port write did not drive pin");
  // Soft reset releases every port
  a_soft_reset: assert property (@(posedge i_core_clk) disable iff (i_srst) // R14
    soft_rst |=> (o_port_pins_oe == 16'h0000))
    else $error("soft reset left a port driven");
  // Deselected bus changes nothing
  a_deselect_hold: assert property (@(posedge i_core_clk) disable iff (i_srst) // R23
    cs_n_s |=> $stable(mask_q) && $stable(mode_q) && $stable(port_dir_q)
      && $stable(port_out_q))
    else $error("state changed while deselected");
  // Mode bit reads back one clock later
  a_mode_read: assert property (@(posedge i_core_clk) disable iff (i_srst) // R3
    (sel_s == 5'h00) |=> (o_serial_read_line == $past(tmr_mode)))
    else $error("mode bit read wrong");
  // Port read returns pin level
  a_port_read: assert property (@(posedge i_core_clk) disable iff (i_srst) // R15
    sel_s[4] |=> (o_serial_read_line == $past(port_lvl[sel_s[3:0]])))
    else $error("port read wrong");

endmodule

`default_nettype wire

// ==== dv/bsi_host.sv ====
// Host model of the bit-serial bus: single-bit writes and reads
`default_nettype none

module bsi_host (
  input wire logic i_core_clk, // Core clock
  input wire logic i_serial_read_line, // Read data from the device
  output logic o_chip_select_n, // Chip select, low
  output logic [4:0] o_bit_select, // Bit number, [4] first line
  output logic o_serial_write_line, // Write data bit
  output logic o_write_strobe // Write strobe
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial
  begin
    o_chip_select_n = 1'b1;
    o_bit_select = 5'h00;
    o_serial_write_line = 1'b0;
    o_write_strobe = 1'b0;
  end

  // Four clocks each side of the strobe, since the device synchronises over two
  task automatic write_bit(input logic [4:0] n, input logic v, input logic cs_n);
    @(negedge i_core_clk);
    o_chip_select_n = cs_n;
    o_bit_select = n;
    o_serial_write_line = v;
    repeat (4) @(negedge i_core_clk);
    o_write_strobe = 1'b1;
    repeat (4) @(negedge i_core_clk);
    o_write_strobe = 1'b0;
    repeat (4) @(negedge i_core_clk);
    o_chip_select_n = 1'b1;
    // Released data line shows the inverse, never a stale copy
    o_serial_write_line = ~v;
  endtask

  // Read line needs three clocks after select, pins two more
  task automatic read_bit(input logic [4:0] n, output logic v);
    @(negedge i_core_clk);
    o_chip_select_n = 1'b0;
    o_bit_select = n;
    repeat (6) @(negedge i_core_clk);
    v = i_serial_read_line;
    o_chip_select_n = 1'b1;
  endtask
endmodule

`default_nettype wire

// ==== dv/bsi_top_bench.sv ====
// Self-checking bench of the serial interrupt and port block
`default_nettype none

module bsi_top_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cs_n, wr_d, strobe, rd, req_n, v;
  logic [4:0] sel;
  logic [3:0] code;
  logic [6:1] irq_n = 6'h3f;
  logic [15:0] pin_drv = 16'hffff;
  logic [15:0] pout, poe, exp_out;
  logic [15:1] pend_n, mask_m, lv;
  logic [4:0] e;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  int k;
  wire logic [15:0] pins_w;

  // Pin level: device drives where enabled, bench elsewhere
  assign pins_w = (poe & pout) | (~poe & pin_drv);

  always #20 clk = ~clk;

  bsi_host hst (.i_core_clk(clk), .i_serial_read_line(rd), .o_chip_select_n(cs_n),
    .o_bit_select(sel), .o_serial_write_line(wr_d), .o_write_strobe(strobe));

  bsi_top dut (.i_core_clk(clk), .i_srst(srst), .i_chip_select_n(cs_n), .i_bit_select(sel),
    .i_serial_write_line(wr_d), .i_write_strobe(strobe), .o_serial_read_line(rd),
    .o_irq_request_n(req_n), .o_level_code(code), .i_irq_inputs_n(irq_n),
    .i_port_pins(pins_w), .o_port_pins(pout), .o_port_pins_oe(poe));

  task automatic results();
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      results();
    end
  end

  task automatic check(input string what, input logic [15:0 ] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Lowest-numbered active slot wins; none gives request high, code 1111
  function automatic logic [4:0] prio(input logic [15:1] act);
    logic [4:0] r;
    r = 5'h1f;
    for (int i = 15; i >= 1; i--)
      if (act[i])
        r = {1'b0, 4'(i)};
    return r;
  endfunction

  // Slots 1..6 on dedicated pins, slot n from 7 up on port pin 22-n
  task automatic set_slots(input logic [15:1] lvl);
    @(negedge clk);
    pend_n = lvl;
    irq_n = lvl[6:1];
    for (int n = 7; n <= 15; n++)
      pin_drv[22 - n] = lvl[n];
    pin_drv[6:0] = 7'($urandom);
  endtask

  // Pin to code takes three clocks; five leaves margin
  task automatic check_irq();
    repeat (5) @(negedge clk);
    check("irq_out", {11'h0, prio(~pend_n & mask_m)}, {11'h0, req_n, code});
  endtask

  initial
  begin
    mask_m = 15'h0000;
    pend_n = 15'h7fff;
    void'($urandom(32'h3fcd));
    repeat (10) @(negedge clk);
    check("reset_code", 16'h0010, {11'h0, req_n, code});
    check("reset_oe", 16'h0000, poe);
    srst = 1'b0;
    hst.read_bit(5'h00, v);
    check("mode_bit", 16'h0000, {15'h0, v});
    for (k = 1; k <= 15; k++)
      hst.write_bit(5'(k), 1'b1, 1'b0);
    mask_m = 15'h7fff;
    set_slots(15'h7fff);
    check_irq();
    set_slots(15'h3fff);
    check_irq();
    // Random slot levels and masks, with the winner then released
    for (int t = 0; t < 40; t++)
    begin
      lv = 15'($urandom);
      if (t % 2 == 1)
        lv = lv | 15'($urandom);
      set_slots(lv);
      check_irq();
      lv = pend_n;
      e = prio(~lv & mask_m);
      if (e[4] == 1'b0)
        lv[e[3:0]] = 1'b1;
      set_slots(lv);
      check_irq();
      k = 1 + $urandom_range(14, 0);
      hst.read_bit(5'(k), v);
      check("slot_level", {15'h0, pend_n[k]}, {15'h0, v});
      k = $urandom_range(15, 0);
      hst.read_bit(5'(16 + k), v);
      check("port_level", {15'h0, pins_w[k]}, {15'h0, v});
      k = 1 + $urandom_range(14, 0);
      v = 1'($urandom);
      hst.write_bit(5'(k), v, 1'b0);
      mask_m[k] = v;
      check_irq();
    end
    set_slots(15'h7fff);
    hst.write_bit(5'h14, 1'b1, 1'b1);
    check("oe_cs_high", 16'h0000, poe);
    for (k = 0; k < 16; k++)
    begin
      v = 1'($urandom);
      hst.write_bit(5'(16 + k), v, 1'b0);
      exp_out[k] = v;
      check("port_oe", 16'h0001, {15'h0, poe[k]});
      check("port_out", {15'h0, v}, {15'h0, pout[k]});
    end
    hst.read_bit(5'h1a, v);
    check("port_hold", exp_out, pout);
    hst.write_bit(5'h00, 1'b1, 1'b0);
    hst.read_bit(5'h00, v);
    check("mode_bit", 16'h0001, {15'h0, v});
    hst.read_bit(5'h0f, v);
    // Slots 7..15 now follow the driven port data
    lv[6:1] = irq_n;
    for (int n = 7; n <= 15; n++)
      lv[n] = exp_out[22 - n];
    e = prio(~lv & mask_m);
    check("req_read", {15'h0, e[4]}, {15'h0, v});
    check("req_pin", {15'h0, e[4]}, {15'h0, req_n});
    hst.write_bit(5'h0f, 1'b0, 1'b0);
    check("oe_soft_reset", 16'h0000, poe);
    hst.write_bit(5'h01, 1'b1, 1'b0);
    hst.write_bit(5'h00, 1'b0, 1'b0);
    hst.write_bit(5'h03, 1'b1, 1'b0);
    mask_m[3] = 1'b1;
    // Pin three low stays hidden while the timer owns its slot
    set_slots(15'h7ffb);
    repeat (5) @(negedge clk);
    check("pin3_hidden", 16'h001f, {11'h0, req_n, code});
    // Start value 1 fires every 64 clocks; other pins idle so only the timer can win
    k = 0;
    while (code !== 4'h3 && k < 400)
    begin
      @(negedge clk);
      k++;
    end
    check("timer_slot", 16'h0003, {12'h0, code});
    hst.write_bit(5'h03, 1'b1, 1'b0);
    check("timer_clear", 16'h001f, {11'h0, req_n, code});
    // Entering timer mode snapshots the count, which start value 1 keeps at 1
    hst.write_bit(5'h00, 1'b1, 1'b0);
    hst.read_bit(5'h01, v);
    check("tmr_bit0", 16'h0001, {15'h0, v});
    hst.read_bit(5'h02, v);
    check("tmr_bit1", 16'h0000, {15'h0, v});
    hst.write_bit(5'h01, 1'b0, 1'b0);
    hst.write_bit(5'h00, 1'b0, 1'b0);
    // Zero start value hands slot three back to its pin
    check_irq();
    set_slots(15'h7fff);
    repeat (80) @(negedge clk);
    check_irq();
    // Reset in mid-run with a port driven and masks set
    hst.write_bit(5'h10, 1'b1, 1'b0);
    @(negedge clk);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    check("reset2_code", 16'h0010, {11'h0, req_n, code});
    check("reset2_oe", 16'h0000, poe);
    srst = 1'b0;
    mask_m = 15'h0000;
    set_slots(15'h0000);
    check_irq();
    results();
  end
endmodule

`default_nettype wire
